// File: rtl/dbgcs_cfg.svh
`ifndef DBGCS_CFG_SVH
`define DBGCS_CFG_SVH
`define DBGCS_OFS_CTRL 2'h0
`define DBGCS_OFS_STAT 2'h1
`define DBGCS_OFS_ABRT 2'h2
`define DBGCS_CTRL_TEST 0
`define DBGCS_CTRL_INTEST 1
`define DBGCS_CTRL_CHAIN0 2
`define DBGCS_CTRL_RESTART 3
`define DBGCS_CTRL_MONITOR 4
`define DBGCS_CTRL_RST 5'h00
`define DBGCS_MODE_RST 5'h00
`define DBGCS_DATA_W 32
`define DBGCS_ADDR_W 2
`endif

// File: rtl/dbgcs_pkg.sv
package dbgcs_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_SWITCH, ST_HALT, ST_RESYNC} dbgcs_state_t;
   typedef struct packed {
      logic fetch;
      logic advance;
      logic flush;
      logic exec_valid;
      logic instr_done;
      logic cop_busy;
      logic exc_pending;
      logic [4:0] exc_mode;
      logic [4:0] cur_mode;
      logic data_xfer;
      logic mreq_n;
      logic seq;
      logic abort;
      logic irq_n;
      logic fiq_n;
   } dbgcs_core_t;
   typedef struct packed {
      logic exec_suppress;
      logic abort_take;
      logic cop_terminate;
      logic abort;
      logic irq_n;
      logic fiq_n;
      logic [4:0] entry_mode;
   } dbgcs_ctl_t;
endpackage : dbgcs_pkg

// File: rtl/dbgcs_top.sv
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "dbgcs_cfg.svh"
module dbgcs_top (
   // Clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // Debug lines
   input wire logic ext_breakpoint_i,
   input wire logic debug_request_i,
   input wire logic debug_enable_i,
   output logic debug_acknowledge_o,
   // Test clock and tap state
   input wire logic test_clock_i,
   input wire logic tap_run_idle_i,
   output logic debug_clock_o,
   output logic core_clock_out_o,
   // Core pipeline
   input wire dbgcs_pkg::dbgcs_core_t core_i,
   output dbgcs_pkg::dbgcs_ctl_t ctl_o,
   // Memory interface
   output logic memory_request_n_o,
   output logic sequential_cycle_o,
   // Avalon-MM slave
   input wire logic [`DBGCS_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [`DBGCS_DATA_W-1:0] avs_writedata,
   output logic [`DBGCS_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest
);
   import dbgcs_pkg::*;

   dbgcs_state_t state_reg, state_next;
   logic [2:0] tck_sync_reg, rq_sync_reg;
   logic tck_lvl_reg, rq_lvl_reg;
   logic dec_tag_reg, exe_tag_reg, wp_pend_reg, rq_pend_reg;
   logic [4:0] ctrl_reg;
   logic abrt_reg, ack_reg, bus_ack_reg, restart_reg;
   logic [4:0] mode_reg;
   logic [`DBGCS_DATA_W-1:0] rdata_reg;
   dbgcs_ctl_t ctl_reg;
   logic mreq_n_reg, seq_reg, debug_clock_reg, core_clock_out_reg;

   // Accepted levels change only when the second and third stages agree
   wire tck_agree = tck_sync_reg[1] == tck_sync_reg[2];
   wire rq_agree = rq_sync_reg[1] == rq_sync_reg[2];
   wire tck_rise = tck_agree && tck_sync_reg[2] && !tck_lvl_reg;
   wire rq_level = rq_agree ? rq_sync_reg[2] : rq_lvl_reg;

   wire monitor = ctrl_reg[`DBGCS_CTRL_MONITOR];
   wire test_mode = ctrl_reg[`DBGCS_CTRL_TEST];
   wire test_clk_ok = ctrl_reg[`DBGCS_CTRL_INTEST] && ctrl_reg[`DBGCS_CTRL_CHAIN0];
   wire running = state_reg == ST_RUN;
   wire halted = state_reg == ST_HALT;
   wire in_debug = !running;

   wire bp_hit = debug_enable_i && running && core_i.exec_valid && exe_tag_reg;
   wire wp_mark = debug_enable_i && core_i.data_xfer && ext_breakpoint_i;
   wire wp_take = debug_enable_i && running && core_i.instr_done && (wp_pend_reg || wp_mark);
   wire rq_now = debug_enable_i && (rq_pend_reg || rq_level);
   wire rq_take = running && rq_now && (core_i.instr_done || core_i.cop_busy);
   wire dbg_event = bp_hit || wp_take;
   wire to_abort = dbg_event && monitor;
   wire to_halt = (dbg_event && !monitor) || rq_take;

   wire bus_req = avs_read || avs_write;
   wire bus_take = bus_req && !bus_ack_reg;
   wire wr_take = avs_write && bus_ack_reg; // Writes land at the edge that ends the wait
   wire wr_ctrl = wr_take && avs_address == `DBGCS_OFS_CTRL;
   wire wr_restart = wr_ctrl && avs_writedata[`DBGCS_CTRL_RESTART];

   logic [`DBGCS_DATA_W-1:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      case (avs_address)
         `DBGCS_OFS_CTRL: rd_mux[4:0] = ctrl_reg;
         `DBGCS_OFS_STAT: rd_mux[7:0] = {mode_reg, state_reg == ST_HALT, debug_enable_i, ack_reg};
         `DBGCS_OFS_ABRT: rd_mux[0] = abrt_reg;
         default: rd_mux = '0;
      endcase
   end

   // Clock switch sequence
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN:
            if (to_halt)
               state_next = ST_SWITCH;
         ST_SWITCH:
            state_next = ST_HALT;
         ST_HALT:
            if (restart_reg)
               state_next = ST_RESYNC;
         ST_RESYNC:
            state_next = ST_RUN;
         default:
            state_next = ST_RUN;
      endcase
      if (!debug_enable_i)
         state_next = ST_RUN;
   end

   // Core clock: memory clock when not halted and not in test mode, test clock edges when halted or in test mode with intest, chain0 and run-idle
   wire debug_clock_next = tck_rise && (halted || (test_mode && test_clk_ok && tap_run_idle_i));
   wire core_clock_out_next = (halted || test_mode) ? debug_clock_next : 1'b1;

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         tck_sync_reg <= 3'h0;
         rq_sync_reg <= 3'h0;
         tck_lvl_reg <= 1'b0;
         rq_lvl_reg <= 1'b0;
      end
      else
      begin
         tck_sync_reg <= {tck_sync_reg[1:0], test_clock_i};
         rq_sync_reg <= {rq_sync_reg[1:0], debug_request_i};
         if (tck_agree)
            tck_lvl_reg <= tck_sync_reg[2];
         rq_lvl_reg <= rq_level;
      end
   end

   // Breakpoint tags follow the instruction down the pipeline
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         dec_tag_reg <= 1'b0;
         exe_tag_reg <= 1'b0;
      end
      else if (core_i.flush)
      begin
         dec_tag_reg <= 1'b0;
         exe_tag_reg <= 1'b0;
      end
      else if (core_i.advance)
      begin
         dec_tag_reg <= core_i.fetch && ext_breakpoint_i && debug_enable_i;
         exe_tag_reg <= dec_tag_reg;
      end
   end

   // Pending watchpoint and request
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wp_pend_reg <= 1'b0;
         rq_pend_reg <= 1'b0;
      end
      else
      begin
         wp_pend_reg <= debug_enable_i && (wp_pend_reg || wp_mark) && !wp_take;
         rq_pend_reg <= rq_now && !rq_take && running;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg <= ST_RUN;
         ack_reg <= 1'b0;
         mode_reg <= `DBGCS_MODE_RST;
      end
      else
      begin
         state_reg <= state_next;
         ack_reg <= state_next != ST_RUN;
         if (to_halt)
            mode_reg <= (wp_take && core_i.exc_pending) ? core_i.exc_mode : core_i.cur_mode;
      end
   end

   // Abort status: debug event wins over a real abort in the same cycle
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         abrt_reg <= 1'b0;
      else if (to_abort)
         abrt_reg <= 1'b1;
      else if (running && core_i.abort)
         abrt_reg <= 1'b0;
   end

   // Core control and memory outputs
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctl_reg <= '0;
         mreq_n_reg <= 1'b1;
         seq_reg <= 1'b0;
         debug_clock_reg <= 1'b0;
         core_clock_out_reg <= 1'b0;
      end
      else
      begin
         ctl_reg.exec_suppress <= bp_hit;
         ctl_reg.abort_take <= to_abort;
         ctl_reg.cop_terminate <= rq_take && core_i.cop_busy;
         ctl_reg.abort <= running && core_i.abort;
         ctl_reg.irq_n <= !running || core_i.irq_n;
         ctl_reg.fiq_n <= !running || core_i.fiq_n;
         ctl_reg.entry_mode <= mode_reg;
         mreq_n_reg <= (state_next != ST_RUN) || core_i.mreq_n;
         seq_reg <= (state_next == ST_RUN) && core_i.seq;
         debug_clock_reg <= debug_clock_next;
         core_clock_out_reg <= core_clock_out_next;
      end
   end

   // Register bus: one wait cycle, then the answer
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl_reg <= `DBGCS_CTRL_RST;
         restart_reg <= 1'b0;
         bus_ack_reg <= 1'b0;
         rdata_reg <= '0;
      end
      else
      begin
         bus_ack_reg <= bus_take;
         restart_reg <= wr_restart;
         if (wr_ctrl)
            ctrl_reg <= avs_writedata[4:0] & ~(5'h1 << `DBGCS_CTRL_RESTART);
         if (avs_read && bus_take)
            rdata_reg <= rd_mux;
      end
   end

   assign avs_waitrequest = bus_req && !bus_ack_reg;
   assign avs_readdata = rdata_reg;
   assign debug_acknowledge_o = ack_reg;
   assign ctl_o = ctl_reg;
   assign memory_request_n_o = mreq_n_reg;
   assign sequential_cycle_o = seq_reg;
   assign debug_clock_o = debug_clock_reg;
   assign core_clock_out_o = core_clock_out_reg;

   default clocking dc @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   ack_disable_a: assert property (!debug_enable_i |=> !debug_acknowledge_o)
      else $error("acknowledge high with debug disabled");
   mreq_idle_a: assert property (debug_acknowledge_o |-> memory_request_n_o && !sequential_cycle_o)
      else $error("memory cycle shown while halted");
   irq_block_a: assert property (halted |=> ctl_o.irq_n && ctl_o.fiq_n && !ctl_o.abort)
      else $error("interrupt passed while halted");
   bp_suppress_a: assert property (bp_hit |=> ctl_o.exec_suppress)
      else $error("tagged instruction not suppressed");
   monitor_abort_a: assert property (to_abort |=> ctl_o.abort_take
      && state_reg == ($past(rq_take) ? ST_SWITCH : ST_RUN))
      else $error("monitor event did not abort");
   clk_switch_a: assert property (to_halt |=> debug_acknowledge_o && state_reg == ST_SWITCH
      ##1 state_reg == ST_HALT)
      else $error("clock switch sequence wrong");
   rq_entry_a: assert property (running && rq_now && core_i.instr_done && debug_enable_i
      |=> state_reg == ST_SWITCH)
      else $error("debug request not taken at instruction end");
   wp_wait_a: assert property (running && !monitor && wp_pend_reg && !core_i.instr_done
      && !rq_take |=> state_reg == ST_RUN)
      else $error("watchpoint taken before instruction end");
   test_clk_a: assert property (test_mode && !halted && !test_clk_ok |=> !debug_clock_o)
      else $error("debug clock made without intest");
   clk_memory_a: assert property (running && !test_mode |=> core_clock_out_o)
      else $error("core clock left memory clock while running");
   debug_clock_idle_a: assert property (running && !test_mode |=> !debug_clock_o)
      else $error("debug clock active in normal running");
endmodule : dbgcs_top

// File: sim/dbgcs_host_model.sv
`timescale 1ns/1ps
module dbgcs_host_model (
   // Bench control
   input wire logic run_i,
   input wire logic idle_i,
   // Test port lines
   output logic test_clock_o,
   output logic tap_run_idle_o
);
   // Test clock toggles only while a scan frame is open, else rests low
   initial test_clock_o = 1'b0;
   always #400 test_clock_o = run_i ? ~test_clock_o : 1'b0;
   assign tap_run_idle_o = idle_i;
endmodule : dbgcs_host_model

// File: sim/tb_top.sv
`timescale 1ns/1ps
`include "dbgcs_cfg.svh"
module tb_top;
   import dbgcs_pkg::*;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic bp = 1'b0, rq = 1'b0, en = 1'b1, run = 1'b0, idle = 1'b0;
   logic ack, debug_clock, cclk, mreq_n, seq_c, tck, tidle, wait_r;
   logic rd = 1'b0, wr = 1'b0;
   logic [1:0] adr = 2'h0;
   logic [31:0] wd = 32'h0, rdata, r;
   logic [4:0] m;
   dbgcs_core_t core = '{mreq_n: 1'b1, irq_n: 1'b1, fiq_n: 1'b1, default: '0};
   dbgcs_ctl_t ctl;
   int miscompares = 0, tests_run = 0, dcnt = 0, skew = 0, aborts = 0, supp = 0, d0, a0;
   logic steady = 1'b0;
   always #50 clock_i = ~clock_i;
   dbgcs_top u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ext_breakpoint_i(bp),
      .debug_request_i(rq), .debug_enable_i(en), .debug_acknowledge_o(ack),
      .test_clock_i(tck), .tap_run_idle_i(tidle), .debug_clock_o(debug_clock),
      .core_clock_out_o(cclk), .core_i(core), .ctl_o(ctl), .memory_request_n_o(mreq_n),
      .sequential_cycle_o(seq_c), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wait_r));
   dbgcs_host_model u_host (.run_i(run), .idle_i(idle), .test_clock_o(tck),
      .tap_run_idle_o(tidle));
   always @(posedge clock_i)
   begin
      dcnt <= dcnt + int'(debug_clock);
      aborts <= aborts + int'(ctl.abort_take);
      supp <= supp + int'(ctl.exec_suppress);
      skew <= skew + int'(steady && (cclk !== debug_clock));
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clock_i);
   endtask : cyc
   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge clock_i);
      while (wait_r !== 1'b0)
         @(posedge clock_i);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clock_i);
   endtask : bus
   task automatic wait_ack(input logic v);
      for (int n = 0; n < 40 && ack !== v; n++)
         @(posedge clock_i);
      chk(ack, v, "acknowledge level");
   endtask : wait_ack
   task automatic watch;
      core.data_xfer <= 1'b1;
      bp <= 1'b1;
      cyc(1);
      core.data_xfer <= 1'b0;
      bp <= 1'b0;
      cyc(2);
      core.instr_done <= 1'b1;
      cyc(1);
      core.instr_done <= 1'b0;
   endtask : watch
   task automatic end_of_test;
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   initial
   begin
      #500000;
      miscompares++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(32'hACF3));
      repeat (4) @(posedge clock_i);
      arst_n_i <= 1'b1;
      cyc(4);
      chk(ack, 1'b0, "ack after reset");
      for (int i = 0; i < 4; i++)
      begin
         m = 5'($urandom) & 5'h16;
         bus(1'b1, 2'h0, {27'h0, m});
         bus(1'b0, 2'h0, 32'h0);
         chk(r, {27'h0, m}, "control readback");
      end
      bus(1'b1, 2'h3, $urandom);
      bus(1'b0, 2'h3, 32'h0);
      chk(r, 32'h0, "unmapped read");
      bus(1'b1, 2'h0, 32'h0);
      en <= 1'b0;
      rq <= 1'b1;
      core.instr_done <= 1'b1;
      cyc(10);
      chk(ack, 1'b0, "request while disabled");
      rq <= 1'b0;
      cyc(6);
      en <= 1'b1;
      rq <= 1'b1;
      core.abort <= 1'b1;
      core.irq_n <= 1'b0;
      core.fiq_n <= 1'b0;
      cyc(2);
      chk(ack, 1'b0, "request passes synchroniser");
      wait_ack(1'b1);
      rq <= 1'b0;
      core.instr_done <= 1'b0;
      cyc(2);
      chk({mreq_n, seq_c}, 2'b10, "internal cycles");
      chk({ctl.abort, ctl.irq_n, ctl.fiq_n}, 3'b011, "aborts ignored");
      bus(1'b0, 2'h1, 32'h0);
      chk(r[2:0], 3'h7, "halted status");
      d0 = dcnt;
      run <= 1'b1;
      steady <= 1'b1;
      cyc(40);
      chk(dcnt > d0, 1'b1, "debug clock while halted");
      chk(skew, 0, "core clock follows debug clock");
      steady <= 1'b0;
      run <= 1'b0;
      core.abort <= 1'b0;
      core.irq_n <= 1'b1;
      core.fiq_n <= 1'b1;
      bus(1'b1, 2'h0, 32'h8);
      wait_ack(1'b0);
      cyc(2);
      chk(cclk, 1'b1, "memory clock resumed");
      d0 = dcnt;
      run <= 1'b1;
      cyc(30);
      chk(dcnt - d0, 0, "debug clock low in run");
      idle <= 1'b1;
      bus(1'b1, 2'h0, 32'h7);
      d0 = dcnt;
      cyc(30);
      chk(dcnt > d0, 1'b1, "intest makes debug clock");
      bus(1'b1, 2'h0, 32'h1);
      cyc(2);
      d0 = dcnt;
      cyc(30);
      chk(dcnt - d0, 0, "extest no debug clock");
      run <= 1'b0;
      idle <= 1'b0;
      bus(1'b1, 2'h0, 32'h8);
      bus(1'b1, 2'h0, 32'h10);
      a0 = aborts;
      watch();
      chk(aborts - a0, 0, "no abort before completion");
      cyc(3);
      chk(aborts - a0, 1, "monitor abort taken");
      chk(ack, 1'b0, "monitor stays running");
      bus(1'b0, 2'h2, 32'h0);
      chk(r[0], 1'b1, "debug event cause");
      core.abort <= 1'b1;
      cyc(1);
      core.abort <= 1'b0;
      bus(1'b0, 2'h2, 32'h0);
      chk(r[0], 1'b0, "memory abort cause");
      bus(1'b1, 2'h0, 32'h0);
      m = 5'($urandom);
      core.exc_mode <= m;
      core.cur_mode <= ~m;
      core.exc_pending <= 1'b1;
      watch();
      wait_ack(1'b1);
      cyc(1);
      chk(ctl.entry_mode, m, "entry mode of exception");
      bus(1'b0, 2'h1, 32'h0);
      chk(r[7:3], m, "status entry mode");
      bus(1'b1, 2'h0, 32'h8);
      wait_ack(1'b0);
      core.exc_pending <= 1'b0;
      core.advance <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         core.fetch <= 1'b1;
         bp <= 1'b1;
         cyc(1);
         core.fetch <= 1'b0;
         bp <= 1'b0;
         core.flush <= k == 0;
         cyc(1);
         core.flush <= 1'b0;
         core.exec_valid <= 1'b1;
         cyc(10);
         chk(ack, k == 1, "tag flushed or acted on");
      end
      chk(supp > 0, 1'b1, "tagged instruction suppressed");
      bus(1'b1, 2'h0, 32'h8);
      wait_ack(1'b0);
      core.exec_valid <= 1'b0;
      core.cop_busy <= 1'b1;
      core.mreq_n <= 1'b0;
      core.seq <= 1'b1;
      cyc(2);
      chk({mreq_n, seq_c}, 2'b01, "memory cycles pass while running");
      rq <= 1'b1;
      wait_ack(1'b1);
      chk(ctl.cop_terminate, 1'b1, "coprocessor wait ended");
      cyc(2);
      chk({mreq_n, seq_c}, 2'b10, "internal cycles over memory cycles");
      end_of_test();
   end
endmodule : tb_top
